// *** rtl/amif_core.sv ***
// Asynchronous memory access sequencer with per-space phase timing and clock-stop handshake.
// Assumes requests and power-unit signals come from logic on i_clk; memory data pins are async.
`timescale 1ns/1ps
`default_nettype none

module amif_core
  import amif_pkg::*;
#(
  parameter int NCS    = 4,
  parameter int ADDR_W = 22
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  input  wire logic [NCS*CFG_W-1:0]  i_chip_select_timing_config,
  input  wire logic                  i_req_valid,
  output logic                       o_req_ready,
  input  wire logic                  i_req_write,
  input  wire logic                  i_req_byte,
  input  wire logic [$clog2(NCS)-1:0] i_req_cs,
  input  wire logic [ADDR_W-1:0]     i_req_addr,
  input  wire logic [15:0]           i_req_wdata,
  output logic [15:0]                o_rdata,
  output logic                       o_rdata_valid,
  output logic                       o_req_error,
  output logic                       o_irq,
  input  wire logic                  i_irq_clear,
  input  wire logic                  i_clk_stop_req,
  output logic                       o_clk_stop_ack,
  output logic [NCS-1:0]             o_mem_cs_n,
  output logic [ADDR_W-1:0]          o_mem_addr,
  output logic                       o_output_enable_strobe_n,
  output logic                       o_mem_we_n,
  output logic [15:0]                o_mem_data_out,
  output logic                       o_mem_data_oe_n,
  input  wire logic [15:0]           i_mem_data_in
);

  // ----------------------------------------------------------------------
  // Field helpers
  // ----------------------------------------------------------------------
  function automatic logic [CNT_W-1:0] fld(input logic [CFG_W-1:0] c, input int lsb,
                                           input int w);
    logic [CFG_W-1:0] m;
    m = (CFG_W'(1) << w) - CFG_W'(1);
    return CNT_W'((c >> lsb) & m);
  endfunction

  function automatic logic [CNT_W-1:0] phase_len(input logic [CFG_W-1:0] c, input logic wr,
                                                 input amif_state_e ph);
    logic [CNT_W-1:0] v;
    v = CNT_ZERO;
    case (ph)
      ST_TURN:   v = fld(c, TURNAROUND_LSB, TURNAROUND_W);
      ST_SETUP:  v = wr ? fld(c, W_SETUP_LSB, SETUP_W) : fld(c, R_SETUP_LSB, SETUP_W);
      ST_STROBE: v = wr ? fld(c, W_STROBE_LSB, STROBE_W) : fld(c, R_STROBE_LSB, STROBE_W);
      ST_HOLD:   v = wr ? fld(c, W_HOLD_LSB, HOLD_W) : fld(c, R_HOLD_LSB, HOLD_W);
      default:   v = CNT_ZERO;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // Data pin synchroniser
  // ----------------------------------------------------------------------
  logic [15:0] din_meta_q;
  logic [15:0] din_sync_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      din_meta_q <= DATA_RST;
      din_sync_q <= DATA_RST;
    end else begin
      din_meta_q <= i_mem_data_in;
      din_sync_q <= din_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------------
  amif_state_e             state_q, state_d;
  logic [CNT_W-1:0]        cnt_q, cnt_d;
  logic                    wr_q, wr_d;
  logic                    last_rd_q, last_rd_d;
  logic [$clog2(NCS)-1:0]  cs_q, cs_d;
  logic [ADDR_W-1:0]       addr_q, addr_d;
  logic [15:0]             wdata_q, wdata_d;
  logic [CFG_W-1:0]        cfg_q, cfg_d;
  logic [15:0]             rdata_q, rdata_d;
  logic                    rvalid_q, rvalid_d;
  logic                    err_q, err_d;
  logic                    irq_q, irq_d;
  logic [CFG_W-1:0]        sel_cfg;
  logic                    accept;

  assign sel_cfg     = i_chip_select_timing_config[i_req_cs*CFG_W +: CFG_W];
  assign o_req_ready = (state_q == ST_IDLE) && !i_clk_stop_req;
  assign accept      = i_req_valid && o_req_ready;

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    wr_d      = wr_q;
    last_rd_d = last_rd_q;
    cs_d      = cs_q;
    addr_d    = addr_q;
    wdata_d   = wdata_q;
    cfg_d     = cfg_q;
    rdata_d   = rdata_q;
    rvalid_d  = 1'b0;
    err_d     = 1'b0;
    irq_d     = irq_q;
    // The sequencer has no halt input, so debug stops never pause it.
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          if (i_req_byte && !sel_cfg[BUS_WIDTH_BIT]) begin
            err_d = 1'b1;
          end else begin
            wr_d   = i_req_write;
            cs_d   = i_req_cs;
            addr_d = i_req_addr;
            cfg_d  = sel_cfg;
            if (i_req_write) begin
              wdata_d = sel_cfg[BUS_WIDTH_BIT] ? (i_req_wdata & BYTE_MASK) : i_req_wdata;
            end
            if (i_req_write && last_rd_q) begin
              state_d = ST_TURN;
              cnt_d   = phase_len(sel_cfg, 1'b1, ST_TURN);
            end else begin
              state_d = ST_SETUP;
              cnt_d   = phase_len(sel_cfg, i_req_write, ST_SETUP);
            end
          end
        end
      end
      ST_TURN: begin
        if (cnt_q == CNT_ZERO) begin
          state_d   = ST_SETUP;
          last_rd_d = 1'b0;
          cnt_d     = phase_len(cfg_q, wr_q, ST_SETUP);
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      ST_SETUP: begin
        if (cnt_q == CNT_ZERO) begin
          state_d = ST_STROBE;
          cnt_d   = phase_len(cfg_q, wr_q, ST_STROBE);
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      ST_STROBE: begin
        if (cnt_q == CNT_ZERO) begin
          state_d = ST_HOLD;
          cnt_d   = phase_len(cfg_q, wr_q, ST_HOLD);
          if (!wr_q) begin
            rdata_d  = cfg_q[BUS_WIDTH_BIT] ? (din_sync_q & BYTE_MASK) : din_sync_q;
            rvalid_d = 1'b1;
          end
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      ST_HOLD: begin
        if (cnt_q == CNT_ZERO) begin
          state_d   = ST_IDLE;
          last_rd_d = !wr_q;
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // A refused access raises the sticky interrupt; a new event wins over a clear.
    if (err_d) begin
      irq_d = 1'b1;
    end else if (i_irq_clear) begin
      irq_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q   <= ST_IDLE;
      cnt_q     <= CNT_ZERO;
      wr_q      <= 1'b0;
      last_rd_q <= 1'b0;
      cs_q      <= '0;
      addr_q    <= '0;
      wdata_q   <= DATA_RST;
      cfg_q     <= CFG_RST;
      rdata_q   <= DATA_RST;
      rvalid_q  <= 1'b0;
      err_q     <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      wr_q      <= wr_d;
      last_rd_q <= last_rd_d;
      cs_q      <= cs_d;
      addr_q    <= addr_d;
      wdata_q   <= wdata_d;
      cfg_q     <= cfg_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
      err_q     <= err_d;
      irq_q     <= irq_d;
    end
  end

  // ----------------------------------------------------------------------
  // Pin and status outputs
  // ----------------------------------------------------------------------
  logic in_access;
  assign in_access = (state_q == ST_SETUP) || (state_q == ST_STROBE) || (state_q == ST_HOLD);

  assign o_mem_cs_n               = in_access ? ~(NCS'(1) << cs_q) : '1;
  assign o_mem_addr               = addr_q;
  assign o_output_enable_strobe_n = !((state_q == ST_STROBE) && !wr_q);
  assign o_mem_we_n               = !((state_q == ST_STROBE) && wr_q);
  assign o_mem_data_out           = wdata_q;
  assign o_mem_data_oe_n          = in_access && !wr_q;
  assign o_rdata                  = rdata_q;
  assign o_rdata_valid            = rvalid_q;
  assign o_req_error              = err_q;
  assign o_irq                    = irq_q;
  assign o_clk_stop_ack           = i_clk_stop_req && (state_q == ST_IDLE);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  irq_raise_a: assert property (o_req_error |-> o_irq)
    else $error("Refused access did not raise the interrupt.");
  byte_refuse_a: assert property (
      (accept && i_req_byte && !sel_cfg[BUS_WIDTH_BIT]) |=> o_req_error && state_q == ST_IDLE)
    else $error("Byte access on a 16-bit bus was not refused.");
  stop_idle_a: assert property (o_clk_stop_ack |-> state_q == ST_IDLE && &o_mem_cs_n)
    else $error("Clock-stop acknowledged during a transfer.");
  stop_hold_a: assert property (
      i_clk_stop_req && state_q == ST_IDLE |=> state_q == ST_IDLE)
    else $error("New access started under a clock-stop request.");
  phase_load_a: assert property (
      (state_q == ST_SETUP && cnt_q == CNT_ZERO)
      |=> state_q == ST_STROBE && cnt_q == phase_len(cfg_q, wr_q, ST_STROBE))
    else $error("Strobe phase did not load its programmed width.");
  phase_count_a: assert property (
      (state_q == ST_HOLD && cnt_q != CNT_ZERO)
      |=> state_q == ST_HOLD && cnt_q == $past(cnt_q) - CNT_ONE)
    else $error("Hold phase count did not step by one.");
  strobe_sel_a: assert property (
      !o_output_enable_strobe_n |-> !wr_q && o_mem_data_oe_n && o_mem_we_n)
    else $error("Read strobe with wrong direction.");
  turn_insert_a: assert property (
      (accept && i_req_write && last_rd_q && (!i_req_byte || sel_cfg[BUS_WIDTH_BIT]))
      |=> state_q == ST_TURN && &o_mem_cs_n && o_mem_we_n
          && cnt_q == phase_len(cfg_q, 1'b1, ST_TURN))
    else $error("No turnaround after a read.");
  cfg_pick_a: assert property (
      (accept && state_d == ST_SETUP) |=> cfg_q == $past(sel_cfg))
    else $error("Timing word of the wrong chip select used.");
  idle_pins_a: assert property (state_q == ST_IDLE |-> &o_mem_cs_n && o_mem_we_n)
    else $error("Memory pins active while idle.");

  read_cov: cover property (state_q == ST_HOLD && !wr_q ##1 state_q == ST_IDLE);
  turn_cov: cover property (state_q == ST_TURN ##1 state_q == ST_SETUP);
  stop_cov: cover property (i_clk_stop_req && !o_clk_stop_ack ##1 o_clk_stop_ack);
  refuse_cov: cover property (o_req_error);

endmodule : amif_core

`default_nettype wire

// *** rtl/amif_pkg.sv ***
// Constants, field layout and state encoding of the asynchronous memory interface.
// Assumes a single 50 MHz interface clock and one chip-select timing word per space.
//
// What this block does
// - The block drives one interrupt line of its own that no other source shares.
// - With no byte-lane pins, a byte access on a 16-bit bus is refused and flagged.
// - On a clock-stop request the block finishes pending transfers and only then acknowledges.
// - Debug breakpoints and emulation halts leave the block running unchanged.
// - Every phase width comes from the timing word of the chip select being accessed.
// - Reads use the read setup, strobe and hold fields and writes use the write ones.
// - Each phase lasts its field value plus one clock cycles.
// - A turnaround period is inserted between a read and a following write.
package amif_pkg;

  // ----------------------------------------------------------------------
  // Timing word layout
  // ----------------------------------------------------------------------
  localparam int CFG_W          = 32;
  localparam int CNT_W          = 6;
  localparam int W_SETUP_LSB    = 0;
  localparam int SETUP_W        = 4;
  localparam int W_STROBE_LSB   = 4;
  localparam int STROBE_W       = 6;
  localparam int W_HOLD_LSB     = 10;
  localparam int HOLD_W         = 3;
  localparam int R_SETUP_LSB    = 13;
  localparam int R_STROBE_LSB   = 17;
  localparam int R_HOLD_LSB     = 23;
  localparam int TURNAROUND_LSB = 26;
  localparam int TURNAROUND_W   = 2;
  localparam int BUS_WIDTH_BIT  = 28;

  // ----------------------------------------------------------------------
  // Reset values and bus sizes
  // ----------------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_ZERO  = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE   = 6'h01;
  localparam logic [15:0]      DATA_RST  = 16'h0000;
  localparam logic [15:0]      BYTE_MASK = 16'h00FF;
  localparam logic [CFG_W-1:0] CFG_RST   = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TURN,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } amif_state_e;

endpackage : amif_pkg

// *** tb/amif_sram_model.sv ***
// Behavioural asynchronous static memory on the far side of the interface.
// Assumes active-low selects and strobes; the bench resolves the shared data pins.
`timescale 1ns/1ps
`default_nettype none
module amif_sram_model (
  input  wire logic [3:0]  i_cs_n,
  input  wire logic [21:0] i_addr,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic [15:0] i_pin,
  output logic      [15:0] o_data,
  output logic             o_drive
);
  logic [15:0] mem [256];
  logic [15:0] last;
  // Write lands on the rising edge of the write enable while selected.
  always @(posedge i_we_n) if (!(&i_cs_n)) mem[i_addr[7:0]] = i_pin;
  assign o_drive = !(&i_cs_n) && !i_oe_n;
  // Released pins show the inverse of the last driven value.
  always @* begin
    if (o_drive) last = mem[i_addr[7:0]];
    o_data = o_drive ? last : ~last;
  end
endmodule // amif_sram_model
`default_nettype wire

// *** tb/amif_core_tb.sv ***
// Self-checking bench of the memory interface core against a reference memory.
// Assumes the package, the core and tb/amif_sram_model.sv are compiled first.
`timescale 1ns/1ps
`default_nettype none
module amif_core_tb;
  import amif_pkg::*;
  logic        i_clk, i_resetn, i_req_valid, i_req_write, i_req_byte, o_req_ready;
  logic        i_irq_clear, i_clk_stop_req, o_rdata_valid, o_req_error, o_irq, o_clk_stop_ack;
  logic        o_output_enable_strobe_n, o_mem_we_n, o_mem_data_oe_n, sram_drv, last_rd;
  logic [1:0]  i_req_cs;
  logic [3:0]  o_mem_cs_n;
  logic [21:0] i_req_addr, o_mem_addr;
  logic [15:0] i_req_wdata, o_rdata, o_mem_data_out, pin, sram_data, seed;
  logic [31:0] cfg [4];
  logic [15:0] ref_m [int];
  int          error_cnt, cmp_count;
  assign pin = o_mem_data_oe_n ? sram_data : o_mem_data_out;
  amif_core amif_core_inst (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_chip_select_timing_config({cfg[3], cfg[2], cfg[1], cfg[0]}),
    .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .i_req_write(i_req_write),
    .i_req_byte(i_req_byte), .i_req_cs(i_req_cs), .i_req_addr(i_req_addr),
    .i_req_wdata(i_req_wdata), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid),
    .o_req_error(o_req_error), .o_irq(o_irq), .i_irq_clear(i_irq_clear),
    .i_clk_stop_req(i_clk_stop_req), .o_clk_stop_ack(o_clk_stop_ack),
    .o_mem_cs_n(o_mem_cs_n), .o_mem_addr(o_mem_addr),
    .o_output_enable_strobe_n(o_output_enable_strobe_n), .o_mem_we_n(o_mem_we_n),
    .o_mem_data_out(o_mem_data_out), .o_mem_data_oe_n(o_mem_data_oe_n), .i_mem_data_in(pin));
  amif_sram_model amif_sram_model_inst (.i_cs_n(o_mem_cs_n), .i_addr(o_mem_addr),
    .i_oe_n(o_output_enable_strobe_n), .i_we_n(o_mem_we_n), .i_pin(pin),
    .o_data(sram_data), .o_drive(sram_drv));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // --------------------------------------------------------------------
  // Checking and access tasks
  // --------------------------------------------------------------------
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int fld(input logic [31:0] w, input int l, input int n);
    return int'((w >> l) & ((32'h1 << n) - 1));
  endfunction
  task automatic results();
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk_n(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      error_cnt++;
      $display("unexpected at %0t: count %0d, want %0d", $time, got, exp);
    end
  endtask
  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: value %h, want %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic by, input logic [1:0] cs,
                     input logic [7:0] ad, input logic [15:0] wd, input logic stop);
    logic [31:0] w;
    logic [15:0] mk, rd;
    logic        rf, er;
    int          s, t, h, fs, lo, sb, dz, vn, bad, first;
    w = cfg[cs];
    mk = w[BUS_WIDTH_BIT] ? BYTE_MASK : 16'hFFFF;
    rf = by && !w[BUS_WIDTH_BIT];
    s = fld(w, wr ? W_SETUP_LSB : R_SETUP_LSB, SETUP_W);
    t = fld(w, wr ? W_STROBE_LSB : R_STROBE_LSB, STROBE_W);
    h = fld(w, wr ? W_HOLD_LSB : R_HOLD_LSB, HOLD_W);
    first = (wr && last_rd) ? fld(w, TURNAROUND_LSB, TURNAROUND_W) + 2 : 1;
    {fs, lo, sb, dz, vn, bad, er, rd} = '0;
    @(posedge i_clk);
    #1 {i_req_write, i_req_byte, i_req_cs, i_req_addr, i_req_wdata} = {wr, by, cs, 14'h0, ad, wd};
    i_req_valid = 1'b1;
    @(posedge i_clk);
    #1 i_req_valid = 1'b0;
    i_clk_stop_req = stop;
    // Sample one cycle per pass, starting in the cycle right after the accepting edge.
    for (int n = 1; n < 300; n++) begin
      if (o_mem_cs_n[cs] === 1'b0) begin
        lo++;
        if (lo == 1) fs = n;
        if (o_mem_addr !== {14'h0, ad}) bad++;
      end
      if ((wr ? o_mem_we_n : o_output_enable_strobe_n) === 1'b0) sb++;
      if (wr && !o_mem_we_n && ((o_mem_data_out ^ wd) & mk) !== 16'h0) bad++;
      if (o_mem_data_oe_n === 1'b1) dz++;
      if (o_rdata_valid === 1'b1) {vn, rd} = {n, o_rdata};
      if (o_req_error === 1'b1) er = 1'b1;
      if (sram_drv && !o_mem_data_oe_n) bad++;
      if (!(&o_mem_cs_n) && o_clk_stop_ack) bad++;
      if (o_req_ready || o_clk_stop_ack) break;
      @(posedge i_clk);
      #1;
    end
    chk_n(bad, 0);
    chk_v({15'h0, er}, {15'h0, rf});
    chk_v({15'h0, o_irq}, {15'h0, rf});
    if (rf) chk_n(lo, 0);
    else begin
      chk_n(fs, first);
      chk_n(lo, s + t + h + 3);
      chk_n(sb, t + 1);
      chk_n(dz, wr ? 0 : s + t + h + 3);
      if (!wr) chk_n(vn, first + s + t + 2);
      // The memory behind every select is one array, so the reference keys on address only.
      if (!wr) chk_v(rd, ref_m[int'(ad)] & mk);
      if (wr) ref_m[int'(ad)] = wd;
      last_rd = !wr;
    end
    if (stop) begin
      chk_v({14'h0, o_clk_stop_ack, o_req_ready}, 16'h0002);
      i_clk_stop_req = 1'b0;
    end
  endtask
  initial begin
    #1_000_000;
    error_cnt++;
    results();
  end
  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    {i_resetn, i_req_valid, i_req_write, i_req_byte, i_irq_clear, i_clk_stop_req} = '0;
    {i_req_cs, i_req_addr, i_req_wdata, error_cnt, cmp_count, last_rd} = '0;
    seed = 16'h003C;
    for (int k = 0; k < 4; k++) begin
      seed = lf(seed);
      cfg[k] = {3'h0, k[0], 2'(seed[13:12]), 3'(seed[11:10]), 6'(seed[9:8]) + 6'h02,
                4'(seed[7:6]), 3'(seed[5:4]), 6'(seed[3:2]), 4'(seed[1:0])};
    end
    repeat (8) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    for (int i = 0; i < 16; i++) begin
      seed = lf(seed);
      acc(1'b1, 1'b0, i[1:0], {2'h0, seed[5:0]}, seed ^ 16'hA5C3, 1'b0);
      acc(1'b0, 1'b0, i[1:0], {2'h0, seed[5:0]}, 16'h0000, 1'b0);
    end
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, 1'b1, k[1:0], 8'hF0, 16'h5A00 + 16'(k), 1'b0);
      if (k[0]) acc(1'b0, 1'b1, k[1:0], 8'hF0, 16'h0000, 1'b0);
      @(posedge i_clk);
      #1 i_irq_clear = 1'b1;
      @(posedge i_clk);
      #1 i_irq_clear = 1'b0;
      chk_v({15'h0, o_irq}, 16'h0000);
    end
    acc(1'b0, 1'b0, 2'd1, 8'hF0, 16'h0000, 1'b1);
    @(posedge i_clk);
    #1 {i_req_cs, i_req_write, i_req_valid} = {2'd2, 1'b0, 1'b1};
    @(posedge i_clk);
    #1 i_req_valid = 1'b0;
    @(posedge i_clk);
    #1 i_resetn = 1'b0;
    @(posedge i_clk);
    #1 chk_v({12'h0, o_mem_cs_n}, 16'h000F);
    last_rd = 1'b0;
    repeat (8) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    acc(1'b1, 1'b0, 2'd2, 8'h11, 16'h1234, 1'b0);
    acc(1'b0, 1'b0, 2'd2, 8'h11, 16'h0000, 1'b0);
    results();
  end
endmodule // amif_core_tb
`default_nettype wire
